/* pkg/power_mode_supervisor_pkg.sv */
// constants, types and carriers of the power mode supervisor
//////////////////////////////////////////////////////////////////////
// Summary of operation
// [RULE1] hold the chip in reset while supply is under POR/POWER_DOWN_RESET or brownout level
// [RULE2] brownout reset is on from power-on at the lowest level
// [RULE3] after supply is good, load option bytes: keep, change or disable brownout
// [RULE4] option bytes pick one of five brownout levels
// [RULE5] optionally switch the internal reference off while in Stop
// [RULE6] supply level detector has seven software-chosen thresholds
// [RULE7] detector interrupt on falling, rising or both crossings
// [RULE8] software must enable the detector; it is off until then
// [RULE9] regulator has main, low-power and off modes; main in Run
// [RULE10] low-power regulator in low-power run, low-power sleep and Stop
// [RULE11] Standby powers the regulator and core down; core state is lost
// [RULE12] return to Run within the latency of each source mode
// [RULE13] wake by communication line adds a delay before Run
// [RULE14] sample boot pins at startup: Flash, system memory or RAM
// [RULE15] system memory boot runs the loader over either serial port
// [RULE16] leave Standby within 60 us on reset, watchdog, wake pin or clock event
// [RULE17] core reset stays on until option byte load is done
package power_mode_supervisor_pkg;
  localparam int CLK_MHZ = 200;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0c;
  localparam int CTRL_SLD_EN = 0;
  localparam int CTRL_SLD_LVL = 1;
  localparam int CTRL_TRIG_FALL = 4;
  localparam int CTRL_TRIG_RISE = 5;
  localparam int CTRL_VREF_AUTO = 6;
  localparam int CTRL_MODE = 8;
  localparam int EVT_SLD_FALL = 0;
  localparam int EVT_SLD_RISE = 1;
  localparam int EVT_WAKE_DONE = 2;
  localparam int T_SLEEP_NS = 400;
  localparam int T_LPRUN_NS = 3000;
  localparam int T_LPSLEEP_NS = 46000;
  localparam int T_STOP_NS = 8000;
  localparam int T_STANDBY_NS = 58000;
  localparam int T_COMM_NS = 100;
  localparam logic [13:0] SLEEP_CYC = 14'(T_SLEEP_NS * CLK_MHZ / 1000);
  localparam logic [13:0] LPRUN_CYC = 14'(T_LPRUN_NS * CLK_MHZ / 1000);
  localparam logic [13:0] LPSLEEP_CYC = 14'(T_LPSLEEP_NS * CLK_MHZ / 1000);
  // stop latency is strictly below the figure
  localparam logic [13:0] STOP_CYC = 14'(T_STOP_NS * CLK_MHZ / 1000 - 1);
  localparam logic [13:0] STANDBY_CYC = 14'(T_STANDBY_NS * CLK_MHZ / 1000);
  localparam logic [13:0] COMM_CYC = 14'(T_COMM_NS * CLK_MHZ / 1000);
  localparam logic [2:0] BOR_LVL_RST = 3'h0;
  localparam logic [2:0] BOR_LVL_MAX = 3'h4;
  localparam logic [2:0] SLD_LVL_MAX = 3'h6;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam int S_POR = 0;
  localparam int S_BOR = 1;
  localparam int S_SLD = 2;
  localparam int S_BOOT = 3;
  localparam int S_WKP = 5;
  localparam int S_XRST = 7;
  localparam int S_INDEPENDENT_WATCHDOG = 8;
  localparam int S_RTC = 9;
  localparam int S_EXTERNAL_INTERRUPT_CONTROLLER = 10;
  localparam int S_COMM = 11;
  localparam int NSYNC = 12;
  typedef enum logic [2:0] {
    M_RUN = 3'h0, M_SLEEP = 3'h1, M_LPRUN = 3'h2,
    M_LPSLEEP = 3'h3, M_STOP = 3'h4, M_STANDBY = 3'h5
  } mode_req_e;
  typedef enum logic [1:0] {REG_MAIN = 2'h0, REG_LP = 2'h1, REG_OFF = 2'h2} reg_mode_e;
  typedef enum logic [1:0] {BOOT_FLASH = 2'h0, BOOT_SYSMEM = 2'h1, BOOT_RAM = 2'h3} boot_src_e;
  typedef enum logic [8:0] {
    ST_RESET = 9'h001, ST_OPTLOAD = 9'h002, ST_RUN = 9'h004,
    ST_SLEEP = 9'h008, ST_LPRUN = 9'h010, ST_LPSLEEP = 9'h020,
    ST_STOP = 9'h040, ST_STANDBY = 9'h080, ST_WAKE = 9'h100
  } state_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;
  typedef struct packed {
    logic bor_dis;
    logic [2:0] bor_lvl;
  } opt_byte_s;
endpackage

/* rtl/power_mode_supervisor.sv */
// power mode supervisor: supply resets, option load, detector, modes, wake
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module power_mode_supervisor
  import power_mode_supervisor_pkg::*;
#(
  parameter logic [13:0] LPSLEEP_WAKE_CYC = LPSLEEP_CYC,
  parameter logic [13:0] STANDBY_WAKE_CYC = STANDBY_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // register bus
  input wire apb_req_s apb_i,
  output apb_rsp_s apb_o,
  // analogue comparators, asynchronous
  input wire logic por_ok_i,
  input wire logic bor_above_i,
  input wire logic sld_above_i,
  // boot pins and wake sources, asynchronous
  input wire logic [1:0] boot_pins_i,
  input wire logic [1:0] wakeup_pin_i,
  input wire logic external_reset_pin_i,
  input wire logic independent_watchdog_i,
  input wire logic rtc_event_i,
  input wire logic external_interrupt_controller_wake_i,
  input wire logic comm_wake_i,
  // option byte loader
  output logic opt_req_o,
  input wire logic opt_valid_i,
  input wire opt_byte_s opt_i,
  // analogue and power controls
  output logic chip_rst_n_o,
  output logic core_rst_n_o,
  output logic core_pwr_o,
  output reg_mode_e reg_mode_o,
  output logic vref_on_o,
  output logic bor_en_o,
  output logic [2:0] bor_level_o,
  output logic sld_en_o,
  output logic [2:0] sld_level_o,
  output boot_src_e boot_src_o,
  output logic loader_en_o,
  output state_e mode_o,
  output logic irq_o
);

  typedef struct packed {
    state_e st;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [13:0] cnt;
    logic from_stby;
    logic [31:0] ctrl;
    logic [2:0] stat;
    logic [2:0] mask;
    apb_rsp_s rsp;
    logic irq;
    logic bor_en;
    logic [2:0] bor_lvl;
    boot_src_e boot;
    logic chip_ok;
    logic core_rst_n;
    reg_mode_e regm;
    logic vref;
    logic opt_req;
    logic core_pwr;
    logic loader;
  } state_s;

  state_s q;
  state_s next_q;

  logic acc;
  logic wr;
  logic rd;
  logic sld_fall;
  logic sld_rise;
  logic [NSYNC-1:0] rise;
  logic [2:0] lvl;
  mode_req_e req;
  logic [13:0] lat;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_q = q;
    acc = apb_i.psel && apb_i.penable;
    wr = acc && q.rsp.pready && apb_i.pwrite;
    rd = acc && !q.rsp.pready && !apb_i.pwrite;
    rise = q.s2 & ~q.s3;
    req = mode_req_e'(q.ctrl[CTRL_MODE +: 3]);
    lat = SLEEP_CYC;
    lvl = 3'h0;

    // pins pass two flops; s3 only holds the previous synced value
    next_q.s1 = {comm_wake_i, external_interrupt_controller_wake_i, rtc_event_i,
      independent_watchdog_i, external_reset_pin_i, wakeup_pin_i,
      boot_pins_i, sld_above_i, bor_above_i, por_ok_i};
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;

    // supply supervisor
    next_q.chip_ok = q.s2[S_POR] && (q.s2[S_BOR] || !q.bor_en); // see [RULE1]

    // detector edges only count while software has it on
    sld_fall = q.ctrl[CTRL_SLD_EN] && q.s3[S_SLD] && !q.s2[S_SLD]; // see [RULE8]
    sld_rise = q.ctrl[CTRL_SLD_EN] && rise[S_SLD];

    // bus response, one wait state
    next_q.rsp.pready = acc && !q.rsp.pready;
    next_q.rsp.pslverr = 1'b0;
    if (rd || (acc && !q.rsp.pready)) begin
      next_q.rsp.prdata = 32'h0;
      case (apb_i.paddr)
        CTRL_OFS: next_q.rsp.prdata = q.ctrl;
        STATUS_OFS: next_q.rsp.prdata = {15'h0, q.st, 1'b0, q.boot,
          q.bor_lvl, q.bor_en, q.s2[S_SLD]};
        INT_STAT_OFS: next_q.rsp.prdata = {29'h0, q.stat};
        INT_MASK_OFS: next_q.rsp.prdata = {29'h0, q.mask};
        default: next_q.rsp.pslverr = 1'b1;
      endcase
    end

    if (wr) begin
      case (apb_i.paddr)
        CTRL_OFS: begin
          next_q.ctrl = apb_i.pwdata & 32'h0000077f;
          lvl = apb_i.pwdata[CTRL_SLD_LVL +: 3];
          // seven levels only
          if (lvl > SLD_LVL_MAX) begin
            next_q.ctrl[CTRL_SLD_LVL +: 3] = SLD_LVL_MAX; // see [RULE6]
          end
          if (apb_i.pwdata[CTRL_MODE +: 3] > 3'(M_STANDBY)) begin
            next_q.ctrl[CTRL_MODE +: 3] = 3'(M_RUN);
          end
        end
        INT_STAT_OFS: next_q.stat = q.stat & ~apb_i.pwdata[2:0];
        INT_MASK_OFS: next_q.mask = apb_i.pwdata[2:0];
        default: next_q.stat = next_q.stat;
      endcase
    end

    // events set after the clear so a same-cycle event survives
    if (sld_fall && q.ctrl[CTRL_TRIG_FALL]) begin
      next_q.stat[EVT_SLD_FALL] = 1'b1; // see [RULE7]
    end
    if (sld_rise && q.ctrl[CTRL_TRIG_RISE]) begin
      next_q.stat[EVT_SLD_RISE] = 1'b1; // see [RULE7]
    end

    //////////////////////////////////////////////////////////////////
    case (q.st)
      ST_RESET: begin
        next_q.core_rst_n = 1'b0;
        if (q.chip_ok) begin
          next_q.st = ST_OPTLOAD; // see [RULE3]
        end
      end
      ST_OPTLOAD: begin
        if (opt_valid_i) begin
          next_q.bor_en = !opt_i.bor_dis; // see [RULE3]
          next_q.bor_lvl = (opt_i.bor_lvl > BOR_LVL_MAX) ? BOR_LVL_MAX
            : opt_i.bor_lvl; // see [RULE4]
          // bit 0 low means flash whatever bit 1 says
          next_q.boot = q.s2[S_BOOT] ? boot_src_e'(q.s2[S_BOOT +: 2])
            : BOOT_FLASH; // see [RULE14]
          next_q.core_rst_n = 1'b1; // see [RULE17]
          next_q.st = ST_RUN;
        end
      end
      ST_RUN: begin
        case (req)
          M_SLEEP: next_q.st = ST_SLEEP;
          M_LPRUN: next_q.st = ST_LPRUN;
          M_LPSLEEP: next_q.st = ST_LPSLEEP;
          M_STOP: next_q.st = ST_STOP;
          M_STANDBY: begin
            // core domain and its registers are lost
            next_q.st = ST_STANDBY; // see [RULE11]
            next_q.ctrl = CTRL_RST;
            next_q.stat = 3'h0;
            next_q.mask = 3'h0;
            next_q.core_rst_n = 1'b0;
          end
          default: next_q.st = ST_RUN;
        endcase
      end
      ST_LPRUN: begin
        if (req == M_RUN) begin
          next_q.st = ST_WAKE;
          next_q.cnt = LPRUN_CYC; // see [RULE12]
        end else if (req == M_LPSLEEP) begin
          next_q.st = ST_LPSLEEP;
        end
      end
      ST_SLEEP, ST_LPSLEEP, ST_STOP: begin
        if (q.s2[S_EXTERNAL_INTERRUPT_CONTROLLER] || q.s2[S_COMM]) begin
          if (q.st == ST_SLEEP) begin
            lat = SLEEP_CYC;
          end else if (q.st == ST_STOP) begin
            lat = STOP_CYC;
          end else begin
            lat = LPSLEEP_WAKE_CYC;
          end
          next_q.st = ST_WAKE;
          // line wake goes through the interrupt controller first
          next_q.cnt = q.s2[S_COMM] ? 14'(lat + COMM_CYC) : lat; // see [RULE12] [RULE13]
        end
      end
      ST_STANDBY: begin
        if (rise[S_XRST] || rise[S_INDEPENDENT_WATCHDOG] || rise[S_RTC] || |rise[S_WKP +: 2]) begin
          next_q.st = ST_WAKE; // see [RULE16]
          next_q.cnt = STANDBY_WAKE_CYC; // see [RULE12]
          next_q.from_stby = 1'b1;
        end
      end
      ST_WAKE: begin
        next_q.cnt = q.cnt - 14'h1;
        if (q.cnt <= 14'h1) begin
          next_q.st = ST_RUN;
          next_q.ctrl[CTRL_MODE +: 3] = 3'(M_RUN);
          next_q.stat[EVT_WAKE_DONE] = 1'b1;
          next_q.core_rst_n = 1'b1;
          next_q.from_stby = 1'b0;
        end
      end
      default: next_q.st = ST_RESET;
    endcase

    // a supply drop wins over every mode
    if (!q.chip_ok) begin
      next_q.st = ST_RESET; // see [RULE1]
      next_q.core_rst_n = 1'b0;
      next_q.from_stby = 1'b0;
    end

    // regulator follows the next mode so it switches with the state
    case (next_q.st)
      ST_LPRUN, ST_LPSLEEP, ST_STOP: next_q.regm = REG_LP; // see [RULE10]
      ST_STANDBY: next_q.regm = REG_OFF; // see [RULE11]
      ST_WAKE: next_q.regm = next_q.from_stby ? REG_OFF : REG_MAIN;
      default: next_q.regm = REG_MAIN; // see [RULE9]
    endcase
    if (next_q.st == ST_WAKE && next_q.from_stby && next_q.cnt < STANDBY_WAKE_CYC) begin
      // regulator restarts once the wake has begun
      next_q.regm = REG_MAIN;
    end
    next_q.vref = !(next_q.st == ST_STOP && q.ctrl[CTRL_VREF_AUTO]); // see [RULE5]

    next_q.irq = |(next_q.stat & next_q.mask);
    // decoded from the next state so the flopped outputs keep their timing
    next_q.opt_req = (next_q.st == ST_OPTLOAD);
    next_q.core_pwr = (next_q.regm != REG_OFF);
    next_q.loader = (next_q.boot == BOOT_SYSMEM); // see [RULE15]
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      q.st <= ST_RESET;
      q.s1 <= '0;
      q.s2 <= '0;
      q.s3 <= '0;
      q.cnt <= 14'h0;
      q.from_stby <= 1'b0;
      q.ctrl <= CTRL_RST;
      q.stat <= 3'h0;
      q.mask <= 3'h0;
      q.rsp <= '0;
      q.irq <= 1'b0;
      q.bor_en <= 1'b1; // see [RULE2]
      q.bor_lvl <= BOR_LVL_RST; // see [RULE2]
      q.boot <= BOOT_FLASH;
      q.chip_ok <= 1'b0;
      q.core_rst_n <= 1'b0;
      q.regm <= REG_MAIN;
      q.vref <= 1'b1;
      q.opt_req <= 1'b0;
      q.core_pwr <= 1'b1;
      q.loader <= 1'b0;
    end else begin
      q <= next_q;
    end
  end

  //////////////////////////////////////////////////////////////////////
  assign apb_o = q.rsp;
  assign opt_req_o = q.opt_req;
  assign chip_rst_n_o = q.chip_ok;
  assign core_rst_n_o = q.core_rst_n;
  assign core_pwr_o = q.core_pwr;
  assign reg_mode_o = q.regm;
  assign vref_on_o = q.vref;
  assign bor_en_o = q.bor_en;
  assign bor_level_o = q.bor_lvl;
  assign sld_en_o = q.ctrl[CTRL_SLD_EN]; // see [RULE8]
  assign sld_level_o = q.ctrl[CTRL_SLD_LVL +: 3]; // see [RULE6]
  assign boot_src_o = q.boot;
  // loader may use either serial port when booting system memory
  assign loader_en_o = q.loader; // see [RULE15]
  assign mode_o = q.st;
  assign irq_o = q.irq;

endmodule

/* testbench/supply_model.sv */
// far side model: supply comparators, option byte store
`timescale 1ns/100ps
module supply_model
  import power_mode_supervisor_pkg::*;
(
  // bench side
  input wire logic core_clk_i,
  input wire logic [11:0] vdd_mv_i,
  input wire opt_byte_s opt_cfg_i,
  input wire logic [3:0] lag_i,
  // device side
  input wire logic [2:0] bor_level_i,
  input wire logic [2:0] sld_level_i,
  input wire logic opt_req_i,
  output logic por_ok_o,
  output logic bor_above_o,
  output logic sld_above_o,
  output logic opt_valid_o,
  output opt_byte_s opt_o
);
  logic [3:0] cnt = 4'h0;
  // thresholds in mV: brownout 1800 + 300 a step, detector 1850 + 200 a step
  assign por_ok_o = vdd_mv_i >= 12'h5dc;
  assign bor_above_o = vdd_mv_i >= 12'h708 + 12'h12c * bor_level_i;
  assign sld_above_o = vdd_mv_i >= 12'h73a + 12'hc8 * sld_level_i;
  // data is garbage outside the valid cycle so a late sample shows
  assign opt_o = opt_valid_o ? opt_cfg_i : ~opt_cfg_i;
  initial opt_valid_o = 1'b0;
  always @(posedge core_clk_i) begin
    cnt <= opt_req_i ? cnt + 4'h1 : 4'h0;
    opt_valid_o <= opt_req_i && !opt_valid_o && cnt >= lag_i;
  end
endmodule

/* testbench/power_mode_supervisor_monitor.sv */
// port assertions of the power mode supervisor
`timescale 1ns/100ps
module power_mode_supervisor_monitor
  import power_mode_supervisor_pkg::*;
#(
  parameter logic [13:0] LPSLEEP_WAKE_CYC = LPSLEEP_CYC,
  parameter logic [13:0] STANDBY_WAKE_CYC = STANDBY_CYC
) (
  // watched ports
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic por_ok_i,
  input wire logic opt_req_o,
  input wire logic chip_rst_n_o,
  input wire logic core_rst_n_o,
  input wire reg_mode_e reg_mode_o,
  input wire logic vref_on_o,
  input wire boot_src_e boot_src_o,
  input wire logic loader_en_o,
  input wire state_e mode_o
);
  localparam int W1 = LPSLEEP_WAKE_CYC > STOP_CYC ? LPSLEEP_WAKE_CYC : STOP_CYC;
  localparam int WMAX = (STANDBY_WAKE_CYC > W1 ? STANDBY_WAKE_CYC : W1) + COMM_CYC + 2;
  int wake_cnt;
  always_ff @(posedge core_clk_i) begin
    wake_cnt <= (mode_o == ST_WAKE) ? wake_cnt + 1 : 0;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  ////////////////////////////////////////
  chip_hold_a: assert property ((!por_ok_i) [*5] |-> !chip_rst_n_o)
    else $error("chip reset released on low supply");
  core_hold_a: assert property (opt_req_o |-> !core_rst_n_o)
    else $error("core released during option load");
  run_main_a: assert property ((mode_o == ST_RUN) [*2] |-> reg_mode_o == REG_MAIN)
    else $error("run without main regulator");
  lp_reg_a: assert property ((mode_o inside {ST_LPRUN, ST_LPSLEEP, ST_STOP}) [*2]
    |-> reg_mode_o == REG_LP) else $error("low power mode without lp regulator");
  off_reg_a: assert property ((mode_o == ST_STANDBY) [*2]
    |-> reg_mode_o == REG_OFF && !core_rst_n_o) else $error("standby with core powered");
  vref_on_a: assert property ((mode_o != ST_STOP) [*2] |-> vref_on_o)
    else $error("reference off outside stop");
  wake_time_a: assert property (wake_cnt <= WMAX)
    else $error("wake too slow");
  loader_a: assert property (core_rst_n_o |-> loader_en_o == (boot_src_o == BOOT_SYSMEM))
    else $error("loader enable wrong");
endmodule
bind power_mode_supervisor power_mode_supervisor_monitor #(
  .LPSLEEP_WAKE_CYC(LPSLEEP_WAKE_CYC), .STANDBY_WAKE_CYC(STANDBY_WAKE_CYC)
) mon (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .por_ok_i(por_ok_i), .opt_req_o(opt_req_o),
  .chip_rst_n_o(chip_rst_n_o), .core_rst_n_o(core_rst_n_o), .reg_mode_o(reg_mode_o),
  .vref_on_o(vref_on_o), .boot_src_o(boot_src_o), .loader_en_o(loader_en_o), .mode_o(mode_o));

/* testbench/tb_top.sv */
// self-checking bench of the power mode supervisor
`timescale 1ns/100ps
module tb_top;
  import power_mode_supervisor_pkg::*;
  localparam int LPS = 50;
  localparam int SBY = 60;
  logic clk = 0, rstn = 0, xrst = 0, independent_watchdog = 0, rtc = 0, external_interrupt_controller = 0, comm = 0, err;
  logic por_ok, bor_above, sld_above, opt_req, opt_valid, chip_rst_n, core_rst_n;
  logic core_pwr, vref_on, bor_en, sld_en, loader_en, irq;
  logic [1:0] boot = 0, wkp = 0;
  logic [2:0] bor_level, sld_level;
  logic [3:0] lag = 0;
  logic [11:0] vdd = 0;
  logic [31:0] rd;
  apb_req_s apb_i = '0;
  apb_rsp_s apb_o;
  opt_byte_s opt_cfg = '0, opt;
  reg_mode_e reg_mode;
  boot_src_e boot_src;
  state_e mode;
  int bad_count = 0, samples_checked = 0, seed = 32'h97e5, cyc = 0, waited, prev, lv;
  int md[5] = '{1, 3, 3, 4, 2};
  int lim[5] = '{SLEEP_CYC + 6, LPS + 6, LPS + COMM_CYC + 6, STOP_CYC + 6, LPRUN_CYC + 6};
  ////////////////////////////////////////
  power_mode_supervisor #(.LPSLEEP_WAKE_CYC(14'(LPS)), .STANDBY_WAKE_CYC(14'(SBY))) dut (
    .core_clk_i(clk), .rstn_i(rstn), .apb_i(apb_i), .apb_o(apb_o), .por_ok_i(por_ok),
    .bor_above_i(bor_above), .sld_above_i(sld_above), .boot_pins_i(boot), .wakeup_pin_i(wkp),
    .external_reset_pin_i(xrst), .independent_watchdog_i(independent_watchdog), .rtc_event_i(rtc),
    .external_interrupt_controller_wake_i(external_interrupt_controller), .comm_wake_i(comm), .opt_req_o(opt_req), .opt_valid_i(opt_valid),
    .opt_i(opt), .chip_rst_n_o(chip_rst_n), .core_rst_n_o(core_rst_n), .core_pwr_o(core_pwr),
    .reg_mode_o(reg_mode), .vref_on_o(vref_on), .bor_en_o(bor_en), .bor_level_o(bor_level),
    .sld_en_o(sld_en), .sld_level_o(sld_level), .boot_src_o(boot_src),
    .loader_en_o(loader_en), .mode_o(mode), .irq_o(irq));
  supply_model far (.core_clk_i(clk), .vdd_mv_i(vdd), .opt_cfg_i(opt_cfg), .lag_i(lag),
    .bor_level_i(bor_level), .sld_level_i(sld_level), .opt_req_i(opt_req),
    .por_ok_o(por_ok), .bor_above_o(bor_above), .sld_above_o(sld_above),
    .opt_valid_o(opt_valid), .opt_o(opt));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // an idle edge after each transfer keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i <= '0;
    @(posedge clk);
  endtask
  task automatic wait_for(input state_e s);
    waited = 0;
    while (mode !== s && waited < 3000) begin
      @(posedge clk);
      waited++;
    end
    chk("mode", s, mode);
  endtask
  task automatic power_up(input logic [1:0] b, input logic dis);
    lv = $random(seed) & 7;
    opt_cfg <= '{dis, lv[2:0]};
    lag <= 4'($random(seed));
    boot <= b;
    vdd <= (b == 2'h0) ? 12'h6fe : 12'h3e8;
    repeat (10) @(posedge clk);
    chk("chip_rst", 1'h0, chip_rst_n);
    vdd <= 12'hce4;
    wait_for(ST_RUN);
    chk("core_rst", 1'h1, core_rst_n);
    if (!dis) chk("bor_lvl", lv > 4 ? 4 : lv, bor_level);
    chk("bor_en", !dis, bor_en);
    chk("boot", b[0] ? b : 2'h0, boot_src);
  endtask
  task automatic test_done;
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    chk("bor_en", 1'h1, bor_en);
    rstn <= 1'b1;
    power_up(2'h0, 1'b0);
    power_up(2'h1, 1'b0);
    power_up(2'h3, 1'b1);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 1'h1, err);
    apb(1'b1, INT_MASK_OFS, 32'h7);
    vdd <= 12'h726;
    repeat (8) @(posedge clk);
    vdd <= 12'hce4;
    repeat (8) @(posedge clk);
    apb(1'b0, INT_STAT_OFS, 32'h0);
    chk("stat", 32'h0, rd);
    lv = ($random(seed) & 32'hff) % 7;
    apb(1'b1, CTRL_OFS, 32'h31 | (lv << 1));
    chk("sld", lv * 2 + 1, {sld_level, sld_en});
    vdd <= 12'h726 + 12'hc8 * lv[2:0];
    repeat (8) @(posedge clk);
    chk("irq", 1'h1, irq);
    apb(1'b1, INT_MASK_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", 1'h0, irq);
    apb(1'b1, INT_STAT_OFS, 32'h1);
    vdd <= 12'hce4;
    repeat (8) @(posedge clk);
    apb(1'b0, INT_STAT_OFS, 32'h0);
    chk("stat", 32'h2, rd);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, CTRL_OFS, (md[i] << 8) | 32'h40);
      wait_for(state_e'(9'h1 << (md[i] + 2)));
      chk("vref", md[i] != 4, vref_on);
      if (i == 4) apb(1'b1, CTRL_OFS, 32'h40);
      else {comm, external_interrupt_controller} <= (i == 2) ? 2'b10 : 2'b01;
      wait_for(ST_RUN);
      chk("lat", 1'h1, waited <= lim[i]);
      chk("comm", 1'h1, i != 2 || waited >= prev + COMM_CYC);
      prev = waited;
      {comm, external_interrupt_controller} <= 2'b00;
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, CTRL_OFS, 32'h500);
      wait_for(ST_STANDBY);
      chk("core_pwr", 1'h0, core_pwr);
      {rtc, independent_watchdog, xrst, wkp} <= 5'h1 << i;
      wait_for(ST_RUN);
      chk("core_pwr", 1'h1, core_pwr);
      chk("lat", 1'h1, waited <= SBY + 6);
      {rtc, independent_watchdog, xrst, wkp} <= 5'h0;
      apb(1'b0, INT_STAT_OFS, 32'h0);
      chk("stat", 32'h4, rd);
    end
    test_done();
  end
endmodule
